/* hdl/twm_master_tx.v */
// Overview of operation
// - Two roles, transmit and receive; software decides which are legal
// - Flag set suspends transfer; status prescaler masked
// - Start request with enable and flag clear issues START when free
// - After START set flag, status 08
// - Last address bit selects transmit or receive role
// - After write address ack set flag, 18/20/38
// - Data write while flag low discarded, collision set
// - Stop request with flag clear issues STOP
// - Start request mid-transfer gives repeated START, 10
// - On 08 address sent and acknowledge sampled
// - On 10 read address switches to receive role
// - On 18 start/stop bits choose next action
// - On 20 send byte or repeated START
// - Hardware clears stop request after STOP
// - Read bit high, write low, ack low
// - Clock held low while flag set, except after arbitration loss or disable
// - Flag stays cleared after STOP
// - Arbitration loss gives 38; start queues START
`timescale 1ns/100ps
`default_nettype none
`include "twm_map.vh"
module twm_master_tx #(
  parameter QTR_CYC = `TWM_QTR_CYC
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Register port
  input wire [1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Two-wire bus, open drain: enable high pulls the line low
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_o,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  // Processor request
  output reg irq_o
);
  localparam S_IDLE = 3'd0;
  localparam S_WFREE = 3'd1;
  localparam S_START = 3'd2;
  localparam S_BIT = 3'd3;
  localparam S_HOLD = 3'd4;
  localparam S_RST = 3'd5;
  localparam S_STOP = 3'd6;
  localparam S_LOST = 3'd7;
  localparam [31:0] QTR_M1 = QTR_CYC - 1;
  localparam [15:0] QTR_LAST = QTR_M1[15:0];

  wire scl_s;
  wire sda_s;
  reg [2:0] state_r;
  reg [1:0] ph_r;
  reg [3:0] bc_r;
  reg [15:0] cnt_r;
  reg [7:0] data_r;
  reg [7:0] sh_r;
  reg [7:0] status_r;
  reg flag_r;
  reg ack_en_r;
  reg sta_r;
  reg sto_r;
  reg wc_r;
  reg en_r;
  reg ie_r;
  reg is_addr_r;
  reg rep_r;
  reg mr_r;
  reg busy_r;
  reg sda_d_r;
  reg flag_set;
  wire tick;
  wire wr_ctl;
  wire wr_dat;
  wire clr;
  wire [7:0] ctl_rd;

  twm_sync #(.RST_VAL(1'b1)) u_sync_scl (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(scl_i),
    .level_o(scl_s)
  );

  twm_sync #(.RST_VAL(1'b1)) u_sync_sda (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(sda_i),
    .level_o(sda_s)
  );

  assign tick = (cnt_r == QTR_LAST);
  assign wr_ctl = wr_i && (addr_i == `TWM_ADDR_CONTROL);
  assign wr_dat = wr_i && (addr_i == `TWM_ADDR_DATA);
  // Flag clear only moves the sequencer when the same write keeps the unit enabled
  assign clr = wr_ctl && wdata_i[`TWM_CTL_FLAG] && wdata_i[`TWM_CTL_EN];
  assign ctl_rd = {flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};

  // Quarter-bit timebase, free-running, restarted only at reset and at each tick
  always @(posedge sys_clk_i) begin
    if (rst_i || tick) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Bus busy from START and STOP seen on the wires, ours included
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      sda_d_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      sda_d_r <= sda_s;
      if (scl_s && sda_d_r && !sda_s) begin
        busy_r <= 1'b1;
      end else if (scl_s && !sda_d_r && sda_s) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Read data stand one cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `TWM_ADDR_DATA: rdata_o <= data_r;
        `TWM_ADDR_STATUS: rdata_o <= status_r;
        `TWM_ADDR_CONTROL: rdata_o <= ctl_rd;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Data register and write collision
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      data_r <= `TWM_RST_DATA;
      wc_r <= 1'b0;
    end else if (wr_dat) begin
      if (flag_r) begin
        data_r <= wdata_i;
        wc_r <= 1'b0;
      end else begin
        wc_r <= 1'b1;
      end
    end
  end

  // Completion flag: a set in the same cycle as a clear wins
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      flag_r <= flag_set || (flag_r && !(wr_ctl && wdata_i[`TWM_CTL_FLAG]));
      irq_o <= flag_r && ie_r;
    end
  end

  // Sequencer for START, bytes, repeated START and STOP
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      ph_r <= 2'd0;
      bc_r <= 4'd0;
      sh_r <= 8'h00;
      status_r <= `TWM_RST_STATUS;
      ack_en_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      en_r <= 1'b0;
      ie_r <= 1'b0;
      is_addr_r <= 1'b0;
      rep_r <= 1'b0;
      mr_r <= 1'b0;
      flag_set <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      flag_set <= 1'b0;
      if (wr_ctl) begin
        ack_en_r <= wdata_i[`TWM_CTL_ACK];
        sta_r <= wdata_i[`TWM_CTL_STA];
        sto_r <= wdata_i[`TWM_CTL_STO];
        en_r <= wdata_i[`TWM_CTL_EN];
        ie_r <= wdata_i[`TWM_CTL_IE];
      end
      if (wr_ctl && !wdata_i[`TWM_CTL_EN]) begin
        // Disabling drops the bus at once, mid-byte or not
        state_r <= S_IDLE;
        scl_oe_o <= 1'b0;
        sda_oe_o <= 1'b0;
        mr_r <= 1'b0;
        status_r <= `TWM_ST_NONE;
      end else begin
        case (state_r)
          S_IDLE: begin
            if (clr && wdata_i[`TWM_CTL_STA]) begin
              state_r <= S_WFREE;
              rep_r <= 1'b0;
            end
            if (clr && wdata_i[`TWM_CTL_STO] && !wdata_i[`TWM_CTL_STA]) begin
              sto_r <= 1'b0;
            end
          end
          S_WFREE: begin
            if (!busy_r && scl_s && sda_s && tick) begin
              sda_oe_o <= 1'b1;
              state_r <= S_START;
            end
          end
          S_START: begin
            if (tick) begin
              scl_oe_o <= 1'b1;
              flag_set <= 1'b1;
              status_r <= rep_r ? `TWM_ST_RSTART : `TWM_ST_START;
              is_addr_r <= 1'b1;
              mr_r <= 1'b0;
              state_r <= S_HOLD;
            end
          end
          S_HOLD: begin
            scl_oe_o <= 1'b1;
            if (clr && wdata_i[`TWM_CTL_STO]) begin
              state_r <= S_STOP;
              ph_r <= 2'd0;
            end else if (clr && wdata_i[`TWM_CTL_STA]) begin
              state_r <= S_RST;
              ph_r <= 2'd0;
              rep_r <= 1'b1;
            end else if (clr && !mr_r) begin
              sh_r <= data_r;
              bc_r <= 4'd0;
              ph_r <= 2'd0;
              state_r <= S_BIT;
            end
          end
          S_BIT: begin
            if (tick) begin
              case (ph_r)
                2'd0: begin
                  // Ninth bit releases the data line for the acknowledge
                  sda_oe_o <= (bc_r < 4'd8) ? !sh_r[7] : 1'b0;
                  ph_r <= 2'd1;
                end
                2'd1: begin
                  scl_oe_o <= 1'b0;
                  ph_r <= 2'd2;
                end
                2'd2: begin
                  // Wait here while a slave stretches the clock
                  if (scl_s) begin
                    if (bc_r < 4'd8 && sh_r[7] && !sda_s) begin
                      sda_oe_o <= 1'b0;
                      flag_set <= 1'b1;
                      status_r <= `TWM_ST_LOST;
                      state_r <= S_LOST;
                    end else begin
                      if (bc_r == 4'd8) begin
                        sh_r[0] <= sda_s;
                      end
                      ph_r <= 2'd3;
                    end
                  end
                end
                default: begin
                  scl_oe_o <= 1'b1;
                  if (bc_r == 4'd8) begin
                    flag_set <= 1'b1;
                    state_r <= S_HOLD;
                    is_addr_r <= 1'b0;
                    if (is_addr_r && mr_r) begin
                      status_r <= sh_r[0] ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK;
                    end else if (is_addr_r) begin
                      status_r <= sh_r[0] ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK;
                    end else begin
                      status_r <= sh_r[0] ? `TWM_ST_D_NACK : `TWM_ST_D_ACK;
                    end
                  end else begin
                    if (bc_r == 4'd7 && is_addr_r) begin
                      mr_r <= sh_r[7];
                    end
                    sh_r <= {sh_r[6:0], 1'b0};
                    bc_r <= bc_r + 4'd1;
                    ph_r <= 2'd0;
                  end
                end
              endcase
            end
          end
          S_RST: begin
            if (tick) begin
              case (ph_r)
                2'd0: begin
                  sda_oe_o <= 1'b0;
                  ph_r <= 2'd1;
                end
                2'd1: begin
                  scl_oe_o <= 1'b0;
                  ph_r <= 2'd2;
                end
                default: begin
                  if (scl_s) begin
                    sda_oe_o <= 1'b1;
                    state_r <= S_START;
                  end
                end
              endcase
            end
          end
          S_STOP: begin
            if (tick) begin
              case (ph_r)
                2'd0: begin
                  sda_oe_o <= 1'b1;
                  ph_r <= 2'd1;
                end
                2'd1: begin
                  scl_oe_o <= 1'b0;
                  ph_r <= 2'd2;
                end
                2'd2: begin
                  if (scl_s) begin
                    sda_oe_o <= 1'b0;
                    ph_r <= 2'd3;
                  end
                end
                default: begin
                  // No flag after a STOP; a pending start goes on after it
                  sto_r <= 1'b0;
                  status_r <= `TWM_ST_NONE;
                  rep_r <= 1'b0;
                  state_r <= sta_r ? S_WFREE : S_IDLE;
                end
              endcase
            end
          end
          default: begin
            // Arbitration lost: bus released, only a queued START can follow
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            if (clr) begin
              rep_r <= 1'b0;
              status_r <= `TWM_ST_NONE;
              state_r <= wdata_i[`TWM_CTL_STA] ? S_WFREE : S_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule // twm_master_tx
`default_nettype wire

/* include/twm_map.vh */
`ifndef TWM_MAP_VH
`define TWM_MAP_VH
// Register offsets
`define TWM_ADDR_DATA 2'h0
`define TWM_ADDR_STATUS 2'h1
`define TWM_ADDR_CONTROL 2'h2
// bus_control field positions
`define TWM_CTL_FLAG 7
`define TWM_CTL_ACK 6
`define TWM_CTL_STA 5
`define TWM_CTL_STO 4
`define TWM_CTL_WC 3
`define TWM_CTL_EN 2
`define TWM_CTL_IE 0
// Reset values
`define TWM_RST_CONTROL 8'h00
`define TWM_RST_DATA 8'hFF
`define TWM_RST_STATUS 8'hF8
// Status codes, prescaler bits zero
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_D_ACK 8'h28
`define TWM_ST_D_NACK 8'h30
`define TWM_ST_LOST 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_NONE 8'hF8
// Timing: quarter of a bus bit period
`define TWM_QTR_NS 2500
`define TWM_CLK_NS 25
`define TWM_QTR_CYC ((`TWM_QTR_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS)
`endif

/* hdl/twm_sync.v */
`timescale 1ns/100ps
`default_nettype none
module twm_sync #(
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Asynchronous level in, filtered level out
  input wire async_i,
  output reg level_o
);
  reg ff1_r;
  reg ff2_r;
  reg ff3_r;

  // A change is taken only once the second and third stages agree
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      ff1_r <= async_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      if (ff2_r == ff3_r) begin
        level_o <= ff3_r;
      end
    end
  end
endmodule // twm_sync
`default_nettype wire

/* test/twm_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module twm_slave #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Bus levels and pulls
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic stretch_i,
  output logic scl_pull_o = 1'b0,
  output logic sda_pull_o = 1'b0,
  // Received byte
  output logic [7:0] byte_o = 8'h00,
  output logic byte_v_o = 1'b0
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic adr = 1'b0;
  logic hit = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  int hold = 0;
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    byte_v_o <= 1'b0;
    if (hold > 0) hold <= hold - 1;
    scl_pull_o <= hold > 1;
    if (scl_i && scl_q && sda_q && !sda_i) begin
      cnt <= 4'h0;
      adr <= 1'b1;
    end else if (scl_i && !scl_q && cnt < 4'h8) begin
      sh <= {sh[6:0], sda_i};
      cnt <= cnt + 4'h1;
      byte_o <= {sh[6:0], sda_i};
      byte_v_o <= cnt == 4'h7;
    end else if (!scl_i && scl_q) begin
      // An unaddressed slave leaves the line to the pull-up, so the master sees NACK
      if (cnt == 4'h8) begin
        sda_pull_o <= adr ? sh[7:1] == ADDR : hit;
        if (adr) hit <= sh[7:1] == ADDR;
        adr <= 1'b0;
        cnt <= 4'h9;
      end else if (cnt == 4'h9) begin
        sda_pull_o <= 1'b0;
        cnt <= 4'h0;
      end
      if (stretch_i) hold <= 12;
    end
  end
endmodule // twm_slave
`default_nettype wire

/* test/twm_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module twm_checker #(
  parameter QTR_CYC = 100
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Bus and request
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic irq_o
);
  localparam int QMAX = 4 * QTR_CYC + 8;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start;
    !scl_oe_o && $rose(sda_oe_o);
  endsequence
  sequence s_stop;
    !scl_oe_o && $fell(sda_oe_o);
  endsequence
  a_status_masked: assert property ($past(rd_i && addr_i == 2'h1) |-> rdata_o[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("bus output not low");
  // Arbitration loss sets the flag with the clock already released, so only a hold is checked
  a_scl_held: assert property (irq_o && $past(irq_o) && $past(scl_oe_o) |-> scl_oe_o)
    else $error("clock released while flag set");
  a_start_clk: assert property (s_start |-> sda_oe_o throughout (##[1:QMAX] scl_oe_o))
    else $error("start not followed by clock low");
  a_stop_quiet: assert property (s_stop |-> (!irq_o && !scl_oe_o) [*3])
    else $error("flag or clock after stop");
  a_reset_idle: assert property ($fell(rst_i) |-> !scl_oe_o && !sda_oe_o && !irq_o)
    else $error("bus driven after reset");
  a_unmapped_zero: assert property ($past(rd_i && addr_i == 2'h3) |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule // twm_checker
bind twm_master_tx twm_checker #(.QTR_CYC(QTR_CYC)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .irq_o(irq_o));
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [6:0] SADDR = 7'h2A;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_q = 1'b0;
  logic stretch = 1'b0;
  wire [7:0] rdata_o;
  wire [7:0] rx_byte;
  wire scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, s_scl, s_sda, rx_v;
  // Pull-ups: a line is high unless some party pulls it
  wire scl = ~scl_oe_o & ~s_scl;
  wire sda = ~sda_oe_o & ~s_sda;
  logic [7:0] exp_rd[$];
  logic [7:0] exp_byte[$];
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  twm_master_tx #(.QTR_CYC(4)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
  twm_slave #(.ADDR(SADDR)) slave (.clk_i(sys_clk_i), .scl_i(scl), .sda_i(sda),
    .stretch_i(stretch), .scl_pull_o(s_scl), .sda_pull_o(s_sda), .byte_o(rx_byte),
    .byte_v_o(rx_v));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask
  // Flag falls a cycle after the clearing write, so skip past the stale level
  task automatic send(input logic [7:0] ctl, input logic [7:0] st);
    wr(2'h2, ctl);
    repeat (2) @(posedge sys_clk_i);
    while (irq_o !== 1'b1) @(posedge sys_clk_i);
    rd(2'h1, st);
  endtask
  task automatic xfer(input logic [7:0] d, input logic [7:0] st);
    exp_byte.push_back(d);
    wr(2'h0, d);
    send(8'h85, st);
  endtask
  always @(posedge sys_clk_i) begin
    rd_q <= rd_i;
    cycles <= cycles + 1;
    if (rd_q) chk(rdata_o, exp_rd.pop_front());
    if (rx_v) chk(rx_byte, exp_byte.pop_front());
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    logic [7:0] b;
    void'($urandom(94));
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(2'h1, 8'hF8);
    rd(2'h2, 8'h00);
    rd(2'h0, 8'hFF);
    wr(2'h3, 8'h5A);
    rd(2'h3, 8'h00);
    send(8'hA5, 8'h08);
    xfer({SADDR, 1'b0}, 8'h18);
    send(8'hA5, 8'h10);
    xfer({SADDR, 1'b0}, 8'h18);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      stretch <= i[0];
      xfer(b, 8'h28);
    end
    stretch <= 1'b0;
    send(8'hA5, 8'h10);
    xfer({~SADDR, 1'b0}, 8'h20);
    b = 8'($urandom);
    xfer(b, 8'h30);
    send(8'hB5, 8'h08);
    xfer({SADDR, 1'b1}, 8'h40);
    wr(2'h2, 8'h95);
    repeat (2) @(posedge sys_clk_i);
    while (sda_oe_o !== 1'b0 || scl_oe_o !== 1'b0) @(posedge sys_clk_i);
    // Stop request bit drops one quarter tick after the data line is released
    repeat (8) @(posedge sys_clk_i);
    rd(2'h2, 8'h05);
    wr(2'h0, 8'h3C);
    rd(2'h2, 8'h0D);
    rd(2'h0, {SADDR, 1'b1});
    repeat (4) @(posedge sys_clk_i);
    results();
  end
endmodule // tb
`default_nettype wire
